// ### verilog/compressed_texel_block_decoder.sv
// decoder of one 128-bit compressed block into one 32-bit argb texel
// assumes the sampler holds block and texel stable while it requests
`timescale 1ns/100ps
module compressed_texel_block_decoder (
    input wire logic clk_i,                         // sampler clock, 125 MHz
    input wire logic sys_rst_i,                     // async reset, active high
    input wire logic req_i,                         // decode request, one clock
    input wire logic [127:0] block_i,               // compressed block
    input wire logic [4:0] texel_i,                 // texel number 0..31
    output logic valid_o,                           // result valid pulse
    output logic [31:0] argb_o,                     // decoded colour
    output logic unsupported_o                      // block mode not decoded here
);

    // decoded mode of the current block
    texel_codec_pkg::block_mode_type mode;
    // selects for this texel
    logic [1:0] sel2;
    logic [2:0] sel3;
    // four base colours of the quad layouts
    logic [23:0] quad_colour [4];
    // operands of the shared mixer
    logic [23:0] mix_a;
    logic [23:0] mix_b;
    logic [2:0] mix_wa;
    logic [2:0] mix_wb;
    logic [1:0] mix_round;
    texel_codec_pkg::divisor_type mix_div;
    logic [23:0] mix_rgb;
    // black-with-clear-alpha entry picked
    logic pick_black;
    // result registers
    logic valid_q;
    logic [31:0] argb_q;
    logic unsupported_q;
    logic [31:0] argb_d;

    function automatic logic [7:0] widen5(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction

    // widen a 6-bit green, top two bits repeated
    function automatic logic [7:0] widen6(input logic [5:0] v);
        return {v, v[5:4]};
    endfunction

    // 15-bit red, green, blue field at lsb, green optionally six bits
    function automatic logic [23:0] base_colour(input logic [127:0] blk, input int lsb,
                                                input logic wide_green, input logic extra);
        logic [14:0] f;
        logic [7:0] g;
        f = blk[lsb +: 15];
        g = wide_green ? widen6({f[9:5], extra}) : widen5(f[9:5]);
        return {widen5(f[14:10]), g, widen5(f[4:0])};
    endfunction

    // mode decode from the top bits
    always_comb begin
        // top bit wins over every other code
        if (block_i[texel_codec_pkg::MODE_HI_BIT]) begin
            mode = texel_codec_pkg::mode_paired;
        // two zero top bits, bit 125 is colour data
        end else if (block_i[texel_codec_pkg::MODE_HI_BIT -: 2] == texel_codec_pkg::EIGHT_STEP_MODE_CODE) begin
            mode = texel_codec_pkg::mode_eight_step;
        // bit 124 is not looked at for this code
        end else if (block_i[texel_codec_pkg::MODE_HI_BIT -: 3] == texel_codec_pkg::DIRECT_MODE_CODE) begin
            mode = texel_codec_pkg::mode_direct;
        end else begin
            // the alpha-bearing code 011 is left to another decoder
            mode = texel_codec_pkg::mode_unsupported;
        end
    end

    // per-texel select fields
    always_comb begin
        sel2 = block_i[{texel_i, 1'b0} +: 2];
        // eight-step selects are three bits, texel 31 at 95:93
        sel3 = block_i[7'(texel_i) * 7'd3 +: 3];
    end

    // base colours of the four-colour layouts
    always_comb begin
        logic alpha_sel;
        logic paired;
        alpha_sel = block_i[texel_codec_pkg::ALPHA_SEL_BIT];
        paired = (mode == texel_codec_pkg::mode_paired);
        // colour n sits at 64 + 15n, red highest
        // in the paired mode, all four greens six bits when alpha-select clear
        // only colours 1 and 3 six bits when alpha-select set
        quad_colour[0] = base_colour(block_i, texel_codec_pkg::QUAD_COLOUR_LSB, paired && !alpha_sel,
            block_i[texel_codec_pkg::GREEN0_XOR_BIT] ^ block_i[texel_codec_pkg::GREEN1_EXTRA_BIT]);
        quad_colour[1] = base_colour(block_i, texel_codec_pkg::QUAD_COLOUR_LSB + 15, paired,
            block_i[texel_codec_pkg::GREEN1_EXTRA_BIT]);
        quad_colour[2] = base_colour(block_i, texel_codec_pkg::QUAD_COLOUR_LSB + 30, paired && !alpha_sel,
            block_i[texel_codec_pkg::GREEN2_XOR_BIT] ^ block_i[texel_codec_pkg::GREEN3_EXTRA_BIT]);
        quad_colour[3] = base_colour(block_i, texel_codec_pkg::QUAD_COLOUR_LSB + 45, paired,
            block_i[texel_codec_pkg::GREEN3_EXTRA_BIT]);
    end

    // table entry as mixer operands; one mixer serves every decoded mode
    always_comb begin
        logic hi_pair;
        hi_pair = texel_i[texel_codec_pkg::PAIR_SPLIT_BIT];
        mix_a = '0;
        mix_b = '0;
        mix_wa = 3'h1;
        mix_wb = 3'h0;
        mix_round = 2'h0;
        mix_div = texel_codec_pkg::div_one;
        pick_black = 1'b0;
        unique case (mode)
            // ((6-k)*c0 + k*c1 + 3)/6, ends fall out exactly
            texel_codec_pkg::mode_eight_step: begin
                mix_a = base_colour(block_i, texel_codec_pkg::EIGHT_COLOUR0_LSB, 1'b0, 1'b0);
                mix_b = base_colour(block_i, texel_codec_pkg::EIGHT_COLOUR1_LSB, 1'b0, 1'b0);
                mix_wa = texel_codec_pkg::EIGHT_STEP_SPAN - sel3;
                mix_wb = sel3;
                mix_round = texel_codec_pkg::ROUND_SIXTH;
                mix_div = texel_codec_pkg::div_six;
                pick_black = (sel3 == texel_codec_pkg::EIGHT_STEP_BLACK);
            end
            texel_codec_pkg::mode_direct: begin
                mix_a = quad_colour[sel2];
            end
            texel_codec_pkg::mode_paired: begin
                // upper half of the texels uses colours 2,3
                mix_a = hi_pair ? quad_colour[2] : quad_colour[0];
                mix_b = hi_pair ? quad_colour[3] : quad_colour[1];
                if (!block_i[texel_codec_pkg::ALPHA_SEL_BIT]) begin
                    // first, two thirds, one third, second
                    unique case (sel2)
                        2'h0: begin
                            mix_wa = 3'h1;
                            mix_wb = 3'h0;
                        end
                        2'h1: begin
                            mix_wa = 3'h2;
                            mix_wb = 3'h1;
                            mix_round = texel_codec_pkg::ROUND_THIRD;
                            mix_div = texel_codec_pkg::div_three;
                        end
                        2'h2: begin
                            mix_wa = 3'h1;
                            mix_wb = 3'h2;
                            mix_round = texel_codec_pkg::ROUND_THIRD;
                            mix_div = texel_codec_pkg::div_three;
                        end
                        2'h3: begin
                            mix_wa = 3'h0;
                            mix_wb = 3'h1;
                        end
                    endcase
                end else begin
                    // index 1 blends, index 3 is clear black
                    unique case (sel2)
                        2'h0: begin
                            mix_wa = 3'h1;
                            mix_wb = 3'h0;
                        end
                        2'h1: begin
                            mix_wa = 3'h1;
                            mix_wb = 3'h1;
                            mix_div = texel_codec_pkg::div_two;
                        end
                        2'h2: begin
                            mix_wa = 3'h0;
                            mix_wb = 3'h1;
                        end
                        2'h3: begin
                            pick_black = 1'b1;
                        end
                    endcase
                end
            end
            texel_codec_pkg::mode_unsupported: begin
                // nothing decodable; answer with clear black
                pick_black = 1'b1;
            end
        endcase
    end

    // shared blend arithmetic
    texel_colour_mixer u_mixer (
        .colour_a_i(mix_a),
        .colour_b_i(mix_b),
        .weight_a_i(mix_wa),
        .weight_b_i(mix_wb),
        .round_i(mix_round),
        .divisor_i(mix_div),
        .rgb_o(mix_rgb)
    );

    // final argb word; black entries carry alpha zero
    always_comb begin
        if (pick_black) begin
            argb_d = {texel_codec_pkg::ALPHA_CLEAR, 24'h000000};
        end else begin
            argb_d = {texel_codec_pkg::ALPHA_OPAQUE, mix_rgb};
        end
    end

    // valid pulse one clock after each request
    // inputs sampled only on the request edge
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= req_i;
        end
    end

    // result held until the next request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            argb_q <= 32'h00000000;
            unsupported_q <= 1'b0;
        end else if (req_i) begin
            argb_q <= argb_d;
            unsupported_q <= (mode == texel_codec_pkg::mode_unsupported);
        end
    end

    assign valid_o = valid_q;
    assign argb_o = argb_q;
    assign unsupported_o = unsupported_q;

endmodule // compressed_texel_block_decoder

// ### common/texel_codec_pkg.sv
// constants, field positions and types shared by the texel block decoder
// assumes a 128-bit block and 32 texels per block; no software-visible registers
package texel_codec_pkg;

    // widths of the request and answer
    localparam int BLOCK_W = 128;        // one compressed block
    localparam int TEXEL_IDX_W = 5;      // texel number 0..31
    localparam int ARGB_W = 32;          // alpha, red, green, blue
    localparam int RGB_W = 24;           // colour without alpha
    localparam int CHAN_W = 8;           // expanded channel
    localparam int SHORT_CHAN_W = 5;     // encoded 5-bit channel
    localparam int COLOUR15_W = 15;      // three 5-bit channels
    localparam int WEIGHT_W = 3;         // blend weight 0..6
    localparam int MIX_SUM_W = 11;       // 6*255+3 fits in 11 bits
    localparam int ROUND_W = 2;          // rounding term 0..3

    // mode field positions
    localparam int MODE_HI_BIT = 127;    // set selects the paired mode
    localparam int MODE_MID_BIT = 126;
    localparam int MODE_LO_BIT = 125;
    localparam int ALPHA_SEL_BIT = 124;  // paired mode table choice
    localparam logic [2:0] DIRECT_MODE_CODE = 3'b010;
    localparam logic [1:0] EIGHT_STEP_MODE_CODE = 2'b00;

    // colour field positions
    localparam int QUAD_COLOUR_LSB = 64;     // colour 0 of four, blue lsb
    localparam int EIGHT_COLOUR0_LSB = 96;   // eight-step colour 0
    localparam int EIGHT_COLOUR1_LSB = 111;  // eight-step colour 1
    localparam int GREEN3_EXTRA_BIT = 126;
    localparam int GREEN1_EXTRA_BIT = 125;
    localparam int GREEN2_XOR_BIT = 33;
    localparam int GREEN0_XOR_BIT = 1;

    // select field widths
    localparam int SEL2_W = 2;
    localparam int SEL3_W = 3;
    localparam int PAIR_SPLIT_BIT = 4;       // texel bit that picks pair 2,3

    // table constants
    localparam logic [WEIGHT_W-1:0] EIGHT_STEP_SPAN = 3'h6;
    localparam logic [SEL3_W-1:0] EIGHT_STEP_BLACK = 3'h7;
    localparam logic [ROUND_W-1:0] ROUND_SIXTH = 2'h3;
    localparam logic [ROUND_W-1:0] ROUND_THIRD = 2'h1;
    localparam logic [7:0] ALPHA_OPAQUE = 8'hff;
    localparam logic [7:0] ALPHA_CLEAR = 8'h00;

    typedef enum logic [1:0] {
        mode_eight_step,
        mode_direct,
        mode_paired,
        mode_unsupported
    } block_mode_type;

    typedef enum logic [1:0] {
        div_one,
        div_two,
        div_three,
        div_six
    } divisor_type;

endpackage

// ### verilog/texel_colour_mixer.sv
// weighted blend of two 24-bit colours, per channel (wa*a + wb*b + r) / d
// purely combinational; the caller registers the result
`timescale 1ns/100ps
module texel_colour_mixer (
    input wire logic [23:0] colour_a_i,                         // first base colour
    input wire logic [23:0] colour_b_i,                         // second base colour
    input wire logic [2:0] weight_a_i,                          // weight of first colour
    input wire logic [2:0] weight_b_i,                          // weight of second colour
    input wire logic [1:0] round_i,                             // rounding term
    input wire texel_codec_pkg::divisor_type divisor_i,         // divisor choice
    output logic [23:0] rgb_o                                   // blended colour
);

    // one loop over red, green, blue; constant divisors only
    always_comb begin
        logic [10:0] sum;
        logic [10:0] quot;
        sum = '0;
        quot = '0;
        rgb_o = '0;
        for (int ch = 0; ch < 3; ch++) begin
            sum = 11'({8'h00, weight_a_i}) * 11'({3'h0, colour_a_i[ch*8 +: 8]})
                + 11'({8'h00, weight_b_i}) * 11'({3'h0, colour_b_i[ch*8 +: 8]})
                + 11'({9'h000, round_i});
            unique case (divisor_i)
                // plain pass of a weighted single colour
                texel_codec_pkg::div_one: begin
                    quot = sum;
                end
                // truncating halve, no rounding term is given
                texel_codec_pkg::div_two: begin
                    quot = sum >> 1;
                end
                texel_codec_pkg::div_three: begin
                    quot = sum / 11'h003;
                end
                texel_codec_pkg::div_six: begin
                    quot = sum / 11'h006;
                end
            endcase
            rgb_o[ch*8 +: 8] = quot[7:0];
        end
    end

endmodule // texel_colour_mixer

// ### verification/texel_sampler_model.sv
// sampler-side model: raises one request per texel and presents block and texel
// assumes the bench says when to issue; released lines show the inverse of the last value
`timescale 1ns/100ps
module texel_sampler_model (
    input wire logic clk_i,           // sampler clock
    input wire logic sys_rst_i,       // async reset, active high
    input wire logic go_i,            // issue a request this cycle
    input wire logic [127:0] blk_i,   // block to send
    input wire logic [4:0] tex_i,     // texel to send
    output logic req_o,               // request to decoder
    output logic [127:0] block_o,     // block to decoder
    output logic [4:0] texel_o        // texel to decoder
);
    logic [127:0] last_blk_q; // last block sent
    logic [4:0] last_tex_q;   // last texel sent

    // remember what was sent, so idle lines can differ from it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_blk_q <= '0;
            last_tex_q <= '0;
        end else if (go_i) begin
            last_blk_q <= blk_i;
            last_tex_q <= tex_i;
        end
    end

    assign req_o = go_i;
    assign block_o = go_i ? blk_i : ~last_blk_q;  // stale data would hide a late sample
    assign texel_o = go_i ? tex_i : ~last_tex_q;
endmodule // texel_sampler_model

// ### verification/compressed_texel_block_decoder_sva.sv
// checker for the texel block decoder, watching its ports only
// assumes one clock domain and an active-high async reset
`timescale 1ns/100ps
module compressed_texel_block_decoder_chk (
    input wire logic clk_i,            // sampler clock
    input wire logic sys_rst_i,        // reset
    input wire logic req_i,            // request
    input wire logic [127:0] block_i,  // block
    input wire logic [4:0] texel_i,    // texel
    input wire logic valid_o,          // result valid
    input wire logic [31:0] argb_o,    // result
    input wire logic unsupported_o     // mode not decoded
);
    logic [2:0] sel3_w;   // eight-step select
    logic [1:0] sel2_w;   // two-bit select
    logic [14:0] quad_w;  // direct colour picked
    logic [23:0] quad_x_w; // its expansion
    logic [23:0] lo_x_w;   // eight-step colour 0 expanded
    logic [23:0] hi_x_w;   // eight-step colour 1 expanded

    assign sel3_w = 3'(block_i >> (texel_i * 3));
    assign sel2_w = 2'(block_i >> (texel_i * 2));
    assign quad_w = 15'(block_i >> (64 + sel2_w * 15));
    assign quad_x_w = {quad_w[14:10], quad_w[14:12], quad_w[9:5], quad_w[9:7], quad_w[4:0], quad_w[4:2]};
    assign lo_x_w = {block_i[110:106], block_i[110:108], block_i[105:101], block_i[105:103],
                     block_i[100:96], block_i[100:98]};
    assign hi_x_w = {block_i[125:121], block_i[125:123], block_i[120:116], block_i[120:118],
                     block_i[115:111], block_i[115:113]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    valid_latency_a: assert property (req_i |=> valid_o) else $error("valid missing after request");
    valid_only_a: assert property (!req_i |=> !valid_o) else $error("valid without request");
    result_hold_a: assert property (!req_i |=> $stable(argb_o) && $stable(unsupported_o))
        else $error("result changed without request");
    unsup_set_a: assert property (req_i && block_i[127:125] == 3'b011 |=> unsupported_o && argb_o == 32'h0)
        else $error("unsupported mode not flagged");
    unsup_clear_a: assert property (req_i && block_i[127:125] != 3'b011 |=> !unsupported_o)
        else $error("unsupported flag wrong");
    eight_black_a: assert property (req_i && block_i[127:126] == 2'b00 && sel3_w == 3'h7 |=> argb_o == 32'h0)
        else $error("eight-step index 7 not black");
    eight_low_a: assert property (req_i && block_i[127:126] == 2'b00 && sel3_w == 3'h0
        |=> argb_o == {8'hff, $past(lo_x_w)}) else $error("eight-step index 0 wrong");
    eight_high_a: assert property (req_i && block_i[127:126] == 2'b00 && sel3_w == 3'h6
        |=> argb_o == {8'hff, $past(hi_x_w)}) else $error("eight-step index 6 wrong");
    direct_pick_a: assert property (req_i && block_i[127:125] == 3'b010
        |=> argb_o == {8'hff, $past(quad_x_w)}) else $error("direct colour wrong");
    paired_black_a: assert property (req_i && block_i[127] && block_i[124] && sel2_w == 2'h3
        |=> argb_o == 32'h0) else $error("paired index 3 not black");
    paired_opaque_a: assert property (req_i && block_i[127] && !block_i[124]
        |=> argb_o[31:24] == 8'hff) else $error("paired alpha not opaque");
endmodule // compressed_texel_block_decoder_chk

bind compressed_texel_block_decoder compressed_texel_block_decoder_chk chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_i(req_i), .block_i(block_i), .texel_i(texel_i), .valid_o(valid_o), .argb_o(argb_o),
    .unsupported_o(unsupported_o));

// ### verification/compressed_texel_block_decoder_tb.sv
// self-checking bench for the texel block decoder with a sampler model in front
// assumes a 125 MHz clock and results one clock after each request
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end
module compressed_texel_block_decoder_tb;
    logic clk_i = 1'b0;          // sampler clock
    logic sys_rst_i = 1'b1;      // reset
    logic go = 1'b0;             // sampler model command
    logic [127:0] blk = '0;      // block to send
    logic [4:0] tex = '0;        // texel to send
    logic req_i;                 // request wire
    logic [127:0] block_i;       // block wire
    logic [4:0] texel_i;         // texel wire
    logic valid_o;               // result valid
    logic [31:0] argb_o;         // result colour
    logic unsupported_o;         // mode flag
    logic req_prev = 1'b0;       // request seen last edge
    logic [32:0] exp_q[$];       // expected flag and colour, in order
    logic [32:0] exp_w;          // expected word now being compared
    int error_cnt = 0;           // mismatches
    int comparisons = 0;         // compares made
    int cycle_cnt = 0;           // timeout counter

    always #4 clk_i = ~clk_i;

    texel_sampler_model sampler (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .blk_i(blk), .tex_i(tex),
        .req_o(req_i), .block_o(block_i), .texel_o(texel_i));
    compressed_texel_block_decoder dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .block_i(block_i),
        .texel_i(texel_i), .valid_o(valid_o), .argb_o(argb_o), .unsupported_o(unsupported_o));

    // widen 5-bit channels by repeating their top bits; g6 uses the extra green bit
    function automatic logic [23:0] ex5(input logic [14:0] c, input logic six, input logic e);
        logic [5:0] g;
        g = six ? {c[9:5], e} : {c[9:5], c[9]};
        return {c[14:10], c[14:12], six ? {g, g[5:4]} : {c[9:5], c[9:7]}, c[4:0], c[4:2]};
    endfunction

    // per-channel (wa*a + wb*b + r) / d
    function automatic logic [23:0] mix(input logic [23:0] a, input logic [23:0] b, input int wa, input int wb,
        input int r, input int d);
        logic [23:0] m;
        for (int i = 0; i < 3; i++) m[8*i+:8] = 8'((wa * a[8*i+:8] + wb * b[8*i+:8] + r) / d);
        return m;
    endfunction

    // reference decode: {unsupported, argb}
    function automatic logic [32:0] ref_decode(input logic [127:0] b, input logic [4:0] t);
        logic [23:0] c[4];
        logic [3:0] e;
        int s;
        e = {b[126], b[33] ^ b[126], b[125], b[1] ^ b[125]};
        if (b[127]) begin
            s = b[2*t+:2];
            for (int i = 0; i < 4; i++) c[i] = ex5(b[64+15*i+:15], !b[124] || i % 2 == 1, e[i]);
            if (t[4]) begin
                c[0] = c[2];
                c[1] = c[3];
            end
            if (b[124]) return s == 3 ? 33'h0 : {9'h0ff, s == 0 ? c[0] : s == 2 ? c[1] : mix(c[0], c[1], 1, 1, 0, 2)};
            return {9'h0ff, s == 0 ? c[0] : s == 3 ? c[1] : mix(c[0], c[1], 3 - s, s, 1, 3)};
        end else if (!b[126]) begin
            s = b[3*t+:3];
            if (s == 7) return 33'h0;
            return {9'h0ff, mix(ex5(b[96+:15], 0, 0), ex5(b[111+:15], 0, 0), 6 - s, s, 3, 6)};
        end else if (!b[125]) begin
            s = b[2*t+:2];
            return {9'h0ff, ex5(b[64+15*s+:15], 0, 0)};
        end
        return {1'b1, 32'h0};
    endfunction

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one request, held one clock; stays high for back-to-back calls
    task automatic issue(input logic [127:0] b, input logic [4:0] t);
        go = 1'b1;
        blk = b;
        tex = t;
        exp_q.push_back(ref_decode(b, t));
        @(posedge clk_i);
        #1;
    endtask

    task automatic idle(input int n);
        go = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // all 32 texels back to back
    task automatic run_blk(input logic [127:0] b);
        for (int t = 0; t < 32; t++) issue(b, 5'(t));
        idle(2);
    endtask

    // result monitor: valid timing and each answer in request order
    always @(posedge clk_i) begin
        cycle_cnt++;
        if (cycle_cnt == 3000) begin
            error_cnt++;
            finish_test;
        end else begin
            if (!sys_rst_i) begin
                `CHK(valid_o, req_prev)
                if (valid_o === 1'b1) begin
                    // pop once: the macro names its expected value twice; no pending request never matches
                    exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
                    `CHK({unsupported_o, argb_o}, exp_w)
                end
            end
            req_prev = req_i;
        end
    end

    task automatic test_reset;
        `CHK({valid_o, unsupported_o, argb_o}, 34'h0)
        $display("test reset done");
    endtask

    task automatic test_eight_step;
        run_blk({32'h3a5c_f0e1, 96'hfac688_fac688_fac688_fac688});
        run_blk({32'h0bff_8000, 96'h05397b_fac688_000fff_e4e4e4});
        $display("test eight step done");
    endtask

    task automatic test_direct;
        run_blk({4'h4, 60'h9d3_a5c7_e1f0_2b86, 64'he4e4_1b1b_e4e4_72d8});
        run_blk({4'h5, 60'h9d3_a5c7_e1f0_2b86, 64'he4e4_1b1b_e4e4_72d8});
        $display("test direct done");
    endtask

    task automatic test_paired;
        run_blk({4'hc, 60'h7e1_0fa3_5c96_d2b4, 64'h72d8_e4e6_e4e4_1b1f});
        run_blk({4'ha, 60'h1b2_f3c4_a596_e787, 64'h72d8_e4e4_e4e4_1b1d});
        run_blk({4'hb, 60'h7e1_0fa3_5c96_d2b4, 64'h72d8_e4e6_e4e4_1b1f});
        run_blk({4'h9, 60'hfff_0421_8c63_5ad6, 64'he41b_d872_27e4_b18d});
        $display("test paired done");
    endtask

    // alpha-bearing code is flagged, then a good block clears the flag
    task automatic test_unsupported;
        issue({4'h6, 124'h1234_5678_9abc_def0_1234_5678_9abc_def}, 5'h0b);
        issue({4'h4, 124'h1234_5678_9abc_def0_1234_5678_9abc_def}, 5'h1f);
        issue({4'h7, 124'h0}, 5'h00);
        idle(2);
        `CHK(unsupported_o, 1'b1)
        $display("test unsupported done");
    endtask

    // result stands while the sampler is idle and its lines change
    task automatic test_hold;
        logic [127:0] b;
        b = {4'h4, 60'h9d3_a5c7_e1f0_2b86, 64'he4e4_1b1b_e4e4_72d8};
        issue(b, 5'h05);
        idle(5);
        `CHK(argb_o, ref_decode(b, 5'h05))
        `CHK(valid_o, 1'b0)
        $display("test hold done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        test_reset;
        #1;
        sys_rst_i = 1'b0;
        idle(1);
        test_eight_step;
        test_direct;
        test_paired;
        test_unsupported;
        test_hold;
        finish_test;
    end
endmodule // compressed_texel_block_decoder_tb
